/* File: rtl/fsdr_pkg.sv */
// Purpose: Shared constants and types for the fault status register bank.
// Assumes: 16-bit registers reached by byte offset over a simple port.
// Notes:   Offsets, status bit positions and reset values live here; the bank places LED view bits 8..0 itself.
package fsdr_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register offsets.
    localparam logic [7:0] BOOST_FAULT_STATUS_OFS      = 8'h10;
    localparam logic [7:0] LED_FAULT_STATUS_OFS        = 8'h12;
    localparam logic [7:0] STATE_MACHINE_DIAG_OFS      = 8'h14;
    localparam logic [7:0] PWM_IN_DUTY_DIAG_OFS        = 8'h16;
    localparam logic [7:0] PWM_OUT_DUTY_DIAG_OFS       = 8'h18;
    localparam logic [7:0] LED_CURRENT_CODE_DIAG_OFS   = 8'h1A;
    localparam logic [7:0] BOOST_VOLTAGE_CODE_DIAG_OFS = 8'h1C;
    localparam logic [7:0] BOOST_INT_EN_OFS            = 8'h20;
    localparam logic [7:0] LED_INT_EN_OFS              = 8'h22;

    ////////////////////////////////////////////////////////////////////////
    // Status bit positions; each clear bit sits one below its status bit.
    localparam int BST_NFLT     = 7;
    localparam int OVERTEMP_CLR_BIT = 14;
    localparam int CUR_RES_BIT  = 13;
    localparam int STR_RES_BIT  = 11;
    localparam int MODE_RES_BIT = 9;
    localparam int FREQ_RES_BIT = 7;
    localparam int BOCP_BIT     = 5;
    localparam int BOVH_BIT     = 3;
    localparam int BOVL_BIT     = 1;
    localparam int LED_NFLT     = 3;
    localparam int TIMEOUT_BIT  = 14;
    localparam int BADSTR_BIT   = 12;
    localparam int ANYLED_BIT   = 10;

    localparam logic [15:0] REG_RESET      = 16'h0000;
    localparam logic [1:0]  INT_EN_ON_WR   = 2'h3;
    localparam logic [1:0]  INT_EN_OFF_WR  = 2'h1;
    localparam logic [1:0]  INT_EN_ON_RD   = 2'h2;
    localparam logic [1:0]  INT_EN_OFF_RD  = 2'h0;
    localparam logic        INT_EN_RESET   = 1'b1;

    // Functional state codes.
    localparam logic [4:0] ST_DISABLED   = 5'h00;
    localparam logic [4:0] ST_NORMAL     = 5'h10;
    localparam logic [4:0] ST_ALL_FAILED = 5'h13;

    ////////////////////////////////////////////////////////////////////////
    // Live diagnostic inputs from the analog and control paths.
    typedef struct packed {
        logic [4:0]  liveStateCode;
        logic [15:0] pwmInDuty;
        logic [15:0] pwmOutDuty;
        logic [11:0] currentDacCode;
        logic [10:0] boostVoltCode;
        logic        ledGroundShortFlag;
        logic        ledInternalShortFlag;
        logic        ledOpenFlag;
        logic [5:0]  chanFault;
    } fsdr_diag_s;

    // One-cycle fault event pulses, boost and LED groups.
    typedef struct packed {
        logic [BST_NFLT-1:0] boost;
        logic [LED_NFLT-1:0] led;
    } fsdr_evt_s;

endpackage

/* File: rtl/fsdr_fault_status_diag_regs.sv */
// Purpose: Fault status and diagnostics register bank with clear pairs.
// Assumes: Register port is synchronous to clk; events are clk pulses.
// Notes:   Reads return data one cycle after the strobe.
`timescale 1ns/100ps

// Notes on behaviour
// RULE_01: Fault clears only when status and clear written.
// RULE_02: Thermal clear bit sits at boost bit 14; nothing sets thermal status bit 15, which always reads zero.
// RULE_03: Current resistor short flag bit 13, clear 12.
// RULE_04: Missing resistor flags at bits 11, 9, 7.
// RULE_05: Boost fault flags at bits 5, 3, 1.
// RULE_06: LED register timeout fault bit 14, clear 13.
// RULE_07: Bad string configuration bit 12, clear 11.
// RULE_08: Summary LED fault bit 10, clear 9.
// RULE_09: Read-only fault type flags bits 8..6.
// RULE_10: Read-only channel fault flags bits 5..0.
// RULE_11: Live state machine code, five bits.
// RULE_12: Measured input PWM duty, sixteen bits.
// RULE_13: Configured output PWM duty, sixteen bits.
// RULE_14: Twelve-bit current DAC code, upper bits zero.
// RULE_15: All status and diagnostics reset to zero.
// RULE_16: Eleven-bit boost voltage code, upper zero.
// RULE_17: Enable writes 3 on, 1 off; reads 2/0.
// RULE_18: Interrupt while any enabled status bit set.
// RULE_19: Lone status or clear write changes nothing.
// RULE_20: Read-only and reserved writes ignored; reserved zero.
module fsdr_fault_status_diag_regs
    import fsdr_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        clkEn,
    input  wire logic        regWrite,
    input  wire logic        regRead,
    input  wire logic [7:0]  regAddr,
    input  wire logic [15:0] regWdata,
    output logic      [15:0] regRdata,
    output logic             regRvalid,
    output logic             faultIrq,
    input  wire fsdr_evt_s   faultEvt,
    input  wire fsdr_diag_s  diagIn
);

    ////////////////////////////////////////////////////////////////////////
    // Status positions per group, index order matches the event vectors except boost index 0.
    localparam int BST_POS [BST_NFLT] = '{OVERTEMP_CLR_BIT + 1, CUR_RES_BIT,
        STR_RES_BIT, MODE_RES_BIT, FREQ_RES_BIT, BOCP_BIT, BOVH_BIT};
    localparam int LED_POS [LED_NFLT] = '{TIMEOUT_BIT, BADSTR_BIT,
        ANYLED_BIT};

    logic [BST_NFLT-1:0] boostFlag_q;
    logic [LED_NFLT-1:0] ledFlag_q;
    logic [BST_NFLT-1:0] boostEn_q;
    logic                boostOvlEn_q;
    logic                boostOvl_q;
    logic [LED_NFLT-1:0] ledEn_q;
    logic [BST_NFLT-1:0] boostClr;
    logic [LED_NFLT-1:0] ledClr;
    logic                ovlClr;
    logic                ovlEvt;
    fsdr_diag_s          diag_q;
    logic [15:0]         rdData_d;
    logic [15:0]         boostView;
    logic [15:0]         ledView;
    logic [15:0]         boostEnView;
    logic [15:0]         ledEnView;
    logic                wrBoost;
    logic                wrLed;

    assign wrBoost = regWrite && regAddr == BOOST_FAULT_STATUS_OFS;
    assign wrLed   = regWrite && regAddr == LED_FAULT_STATUS_OFS;
    // Over-voltage low lives at bit 1, outside the event struct ordering.
    assign ovlEvt  = faultEvt.boost[0];

    ////////////////////////////////////////////////////////////////////////
    // A clear needs both the status bit and the bit just below it set in
    // one write; either alone is harmless so a sloppy read-modify-write
    // cannot drop a fault by accident.
    always_comb
    begin
        for (int i = 0; i < BST_NFLT; i++)
        begin
            boostClr[i] = wrBoost && regWdata[BST_POS[i]]
                          && regWdata[BST_POS[i] - 1]; // RULE_01 RULE_19
        end
        for (int i = 0; i < LED_NFLT; i++)
        begin
            ledClr[i] = wrLed && regWdata[LED_POS[i]]
                        && regWdata[LED_POS[i] - 1]; // RULE_01 RULE_19
        end
        ovlClr = wrBoost && regWdata[BOVL_BIT]
                 && regWdata[BOVL_BIT - 1]; // RULE_01
    end

    ////////////////////////////////////////////////////////////////////////
    // Sticky boost flags. The set wins over a same-cycle clear so that a
    // fault arriving during the clear write is never lost.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            boostFlag_q <= '0; // RULE_15
            boostOvl_q  <= 1'b0;
        end
        else if (clkEn)
        begin
            boostFlag_q <= (boostFlag_q & ~boostClr)
                           | {faultEvt.boost[BST_NFLT-1:1], 1'b0};
            boostOvl_q  <= (boostOvl_q & ~ovlClr) | ovlEvt; // RULE_05
        end
    end

    // Sticky LED flags; each bit, the summary included, is set only by its own faultEvt.led pulse.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            ledFlag_q <= '0; // RULE_15
        end
        else if (clkEn)
        begin
            ledFlag_q <= (ledFlag_q & ~ledClr) | faultEvt.led; // RULE_08
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt enables: 3 turns on, 1 turns off, other codes are ignored.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            boostEn_q    <= {BST_NFLT{INT_EN_RESET}};
            boostOvlEn_q <= INT_EN_RESET;
            ledEn_q      <= {LED_NFLT{INT_EN_RESET}};
        end
        else if (clkEn)
        begin
            for (int i = 0; i < BST_NFLT; i++)
            begin
                if (regWrite && regAddr == BOOST_INT_EN_OFS)
                begin
                    if (regWdata[2*i+:2] == INT_EN_ON_WR)
                        boostEn_q[i] <= 1'b1; // RULE_17
                    else if (regWdata[2*i+:2] == INT_EN_OFF_WR)
                        boostEn_q[i] <= 1'b0; // RULE_17
                end
            end
            if (regWrite && regAddr == BOOST_INT_EN_OFS)
            begin
                if (regWdata[15:14] == INT_EN_ON_WR)
                    boostOvlEn_q <= 1'b1;
                else if (regWdata[15:14] == INT_EN_OFF_WR)
                    boostOvlEn_q <= 1'b0;
            end
            for (int i = 0; i < LED_NFLT; i++)
            begin
                if (regWrite && regAddr == LED_INT_EN_OFS)
                begin
                    if (regWdata[2*i+:2] == INT_EN_ON_WR)
                        ledEn_q[i] <= 1'b1; // RULE_17
                    else if (regWdata[2*i+:2] == INT_EN_OFF_WR)
                        ledEn_q[i] <= 1'b0; // RULE_17
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Diagnostic snapshots are registered so reads see a stable value.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            diag_q <= '0; // RULE_15
        else if (clkEn)
            diag_q <= diagIn; // RULE_11 RULE_12 RULE_13
    end

    // Interrupt is registered; it drops the cycle after the last clear.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            faultIrq <= 1'b0;
        else if (clkEn)
            faultIrq <= |(boostFlag_q[BST_NFLT-1:1] & boostEn_q[BST_NFLT-1:1])
                        | (boostOvl_q & boostOvlEn_q)
                        | |(ledFlag_q & ledEn_q); // RULE_18
    end

    ////////////////////////////////////////////////////////////////////////
    // Read views. Clear bits read back zero; reserved bits read zero.
    always_comb
    begin
        boostView   = '0;
        ledView     = '0;
        boostEnView = '0;
        ledEnView   = '0;
        for (int i = 1; i < BST_NFLT; i++)
        begin
            boostView[BST_POS[i]] = boostFlag_q[i]; // RULE_02 RULE_03 RULE_04
        end
        boostView[BOVL_BIT] = boostOvl_q; // RULE_05
        for (int i = 0; i < LED_NFLT; i++)
        begin
            ledView[LED_POS[i]] = ledFlag_q[i]; // RULE_06 RULE_07 RULE_08
            ledEnView[2*i+:2]   = ledEn_q[i] ? INT_EN_ON_RD : INT_EN_OFF_RD;
        end
        for (int i = 0; i < BST_NFLT; i++)
        begin
            boostEnView[2*i+:2] = boostEn_q[i] ? INT_EN_ON_RD
                                               : INT_EN_OFF_RD; // RULE_17
        end
        boostEnView[15:14] = boostOvlEn_q ? INT_EN_ON_RD : INT_EN_OFF_RD;
        ledView[8] = diag_q.ledGroundShortFlag;   // RULE_09
        ledView[7] = diag_q.ledInternalShortFlag; // RULE_09
        ledView[6] = diag_q.ledOpenFlag;          // RULE_09
        ledView[5:0] = diag_q.chanFault;          // RULE_10
        case (regAddr)
            BOOST_FAULT_STATUS_OFS:      rdData_d = boostView;
            LED_FAULT_STATUS_OFS:        rdData_d = ledView;
            STATE_MACHINE_DIAG_OFS:
                rdData_d = {11'h000, diag_q.liveStateCode}; // RULE_11
            PWM_IN_DUTY_DIAG_OFS:        rdData_d = diag_q.pwmInDuty;
            PWM_OUT_DUTY_DIAG_OFS:       rdData_d = diag_q.pwmOutDuty;
            LED_CURRENT_CODE_DIAG_OFS:
                rdData_d = {4'h0, diag_q.currentDacCode}; // RULE_14
            BOOST_VOLTAGE_CODE_DIAG_OFS:
                rdData_d = {5'h00, diag_q.boostVoltCode}; // RULE_16
            BOOST_INT_EN_OFS:            rdData_d = boostEnView;
            LED_INT_EN_OFS:              rdData_d = ledEnView;
            default:                     rdData_d = REG_RESET; // RULE_20
        endcase
    end

    // Read data is captured on the strobe and held until the next read.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            regRdata  <= REG_RESET;
            regRvalid <= 1'b0;
        end
        else if (clkEn)
        begin
            regRvalid <= regRead;
            if (regRead)
                regRdata <= rdData_d;
        end
    end

endmodule

/* File: tb/fsdr_regs_monitor.sv */
// Purpose: Port-level checks on the fault register bank.
// Assumes: One clock; synchronous active-low reset.
// Notes:   Attached by bind to every bank instance.
`timescale 1ns/100ps
module fsdr_regs_monitor
    import fsdr_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        clkEn,
    input wire logic        regWrite,
    input wire logic        regRead,
    input wire logic [7:0]  regAddr,
    input wire logic [15:0] regWdata,
    input wire logic [15:0] regRdata,
    input wire logic        regRvalid,
    input wire logic        faultIrq,
    input wire fsdr_evt_s   faultEvt,
    input wire fsdr_diag_s  diagIn
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    logic rdTaken;
    logic wrTaken;
    logic irqCause;

    // A strobe with the clock enable low is not a request.
    assign rdTaken = clkEn && regRead;
    assign wrTaken = clkEn && regWrite;
    // Only a fault event or a register write may raise the interrupt.
    assign irqCause = (|faultEvt) || wrTaken;

    ////////////////////////////////////////
    // Answer timing, field contents and interrupt causes.
    rd_answer_a: assert property (rdTaken |=> regRvalid)
        else $error("read not answered");
    rd_hold_a: assert property (!rdTaken |=>
        !regRvalid && $stable(regRdata)) else $error("read data moved");
    rst_quiet_a: assert property (disable iff (1'b0)
        !rst_n && clkEn |=> !faultIrq && !regRvalid) else $error("reset");
    state_field_a: assert property (rdTaken && $stable(diagIn) &&
        regAddr == STATE_MACHINE_DIAG_OFS |=>
        regRdata == {11'h000, $past(diagIn.liveStateCode)})
        else $error("state field wrong");
    dac_field_a: assert property (rdTaken && $stable(diagIn) &&
        regAddr == LED_CURRENT_CODE_DIAG_OFS |=>
        regRdata == {4'h0, $past(diagIn.currentDacCode)})
        else $error("current code field wrong");
    vcode_field_a: assert property (rdTaken && $stable(diagIn) &&
        regAddr == BOOST_VOLTAGE_CODE_DIAG_OFS |=>
        regRdata == {5'h00, $past(diagIn.boostVoltCode)})
        else $error("boost code field wrong");
    duty_in_a: assert property (rdTaken && $stable(diagIn) &&
        regAddr == PWM_IN_DUTY_DIAG_OFS |=>
        regRdata == $past(diagIn.pwmInDuty)) else $error("duty wrong");
    unmapped_zero_a: assert property (
        rdTaken && regAddr == 8'h30 |=> regRdata == 16'h0000)
        else $error("unmapped read not zero");
    irq_fall_a: assert property (
        $fell(faultIrq) |-> $past(wrTaken, 2)) else $error("irq fell");
    irq_rise_a: assert property (
        $rose(faultIrq) |-> $past(irqCause, 2))
        else $error("irq rose without cause");

    // Main scenarios reached.
    cover property (rdTaken && regAddr == STATE_MACHINE_DIAG_OFS);
    cover property ($rose(faultIrq));
    cover property ($fell(faultIrq));
endmodule

bind fsdr_fault_status_diag_regs fsdr_regs_monitor mon (
    .clk(clk), .rst_n(rst_n), .clkEn(clkEn), .regWrite(regWrite),
    .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata),
    .regRdata(regRdata), .regRvalid(regRvalid), .faultIrq(faultIrq),
    .faultEvt(faultEvt), .diagIn(diagIn)
);

/* File: tb/fsdr_host_model.sv */
// Purpose: Host side of the register port.
// Assumes: Strobes are one-cycle pulses launched after a clk edge.
// Notes:   Write data is scrambled once released, so stale data helps none.
`timescale 1ns/100ps
module fsdr_host_model
(
    input  wire logic        clk,
    output logic             regWrite,
    output logic             regRead,
    output logic      [7:0]  regAddr,
    output logic      [15:0] regWdata,
    input  wire logic [15:0] regRdata,
    input  wire logic        regRvalid
);
    // Idle bus at time zero.
    initial
    begin
        regWrite = 1'b0;
        regRead  = 1'b0;
        regAddr  = 8'h00;
        regWdata = 16'h0000;
    end

    // One write; a clear sets status and clear bits together.
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        regWrite <= 1'b1;
        regAddr  <= a;
        regWdata <= d;
        @(posedge clk);
        regWrite <= 1'b0;
        regWdata <= ~d;
    endtask

    // One read; ok stays low if no valid pulse shows within eight cycles.
    task automatic rd(input logic [7:0] a, output logic [15:0] d,
                      output logic ok);
        int n;
        @(posedge clk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRead <= 1'b0;
        #1;
        for (n = 0; n < 8 && regRvalid !== 1'b1; n++)
        begin
            @(posedge clk);
            #1;
        end
        d  = regRdata;
        ok = regRvalid;
    endtask
endmodule

/* File: tb/tb_top.sv */
// Purpose: Self-checking bench for the fault register bank.
// Assumes: Enable codes and event mapping as the package defines.
// Notes:   Clock enable drops once to show that frozen state drops events.
`timescale 1ns/100ps
module tb_top import fsdr_pkg::*;;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        clkEn = 1'b1;
    logic        regWrite;
    logic        regRead;
    logic [7:0]  regAddr;
    logic [15:0] regWdata;
    logic [15:0] regRdata;
    logic        regRvalid;
    logic        faultIrq;
    fsdr_evt_s   faultEvt = '0;
    fsdr_diag_s  diagIn = '0;
    int          errors = 0;
    int          check_count = 0;

    // Free-running 100 MHz clock.
    always #5 clk = ~clk;

    fsdr_fault_status_diag_regs dut (.clk(clk), .rst_n(rst_n),
        .clkEn(clkEn), .regWrite(regWrite), .regRead(regRead),
        .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
        .regRvalid(regRvalid), .faultIrq(faultIrq),
        .faultEvt(faultEvt), .diagIn(diagIn));
    fsdr_host_model host (.clk(clk), .regWrite(regWrite),
        .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata),
        .regRdata(regRdata), .regRvalid(regRvalid));

    ////////////////////////////////////////
    // Reporting and shared steps.
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [15:0] exp);
        logic [15:0] d;
        logic        ok;
        host.rd(a, d, ok);
        if (ok !== 1'b1)
        begin
            errors++;
            summarize();
        end
        else
            chk(d, exp);
    endtask
    task automatic irq(input logic exp);
        chk({15'h0000, faultIrq}, {15'h0000, exp});
    endtask
    task automatic pulse(input fsdr_evt_s e);
        @(posedge clk);
        faultEvt <= e;
        @(posedge clk);
        faultEvt <= '0;
    endtask
    // Raise one fault, try lone writes, then clear it with the pair.
    task automatic t_clear(input logic [7:0] a, input int b,
                           input fsdr_evt_s e);
        logic [15:0] s;
        s = 16'h0001 << b;
        pulse(e);
        rdchk(a, s);
        irq(1'b1);
        host.wr(a, s);
        host.wr(a, s >> 1);
        rdchk(a, s);
        irq(1'b1);
        host.wr(a, s | (s >> 1));
        rdchk(a, REG_RESET);
        irq(1'b0);
    endtask

    ////////////////////////////////////////
    // Scenarios.
    task automatic t_faults();
        fsdr_evt_s e;
        rdchk(BOOST_FAULT_STATUS_OFS, REG_RESET);
        rdchk(LED_FAULT_STATUS_OFS, REG_RESET);
        for (int i = 0; i < 7; i++)
        begin
            e = '0;
            e.boost[i] = 1'b1;
            // Event 0 is over-voltage low; the rest run down from bit 13.
            t_clear(BOOST_FAULT_STATUS_OFS, (i == 0) ? 1 : 15 - 2 * i,
                    e);
        end
        for (int i = 0; i < 3; i++)
        begin
            e = '0;
            e.led[i] = 1'b1;
            t_clear(LED_FAULT_STATUS_OFS, 14 - 2 * i, e);
        end
    endtask
    task automatic t_enable();
        fsdr_evt_s e;
        e = '0;
        e.led[0] = 1'b1;
        rdchk(LED_INT_EN_OFS, 16'h002A);
        host.wr(LED_INT_EN_OFS, 16'h0002);
        rdchk(LED_INT_EN_OFS, 16'h002A);
        host.wr(LED_INT_EN_OFS, {14'h0000, INT_EN_OFF_WR});
        rdchk(LED_INT_EN_OFS, 16'h0028);
        pulse(e);
        rdchk(LED_FAULT_STATUS_OFS, 16'h4000);
        irq(1'b0);
        host.wr(LED_INT_EN_OFS, {14'h0000, INT_EN_ON_WR});
        rdchk(LED_INT_EN_OFS, 16'h002A);
        irq(1'b1);
        host.wr(LED_FAULT_STATUS_OFS, 16'h6000);
        rdchk(LED_FAULT_STATUS_OFS, REG_RESET);
        irq(1'b0);
    endtask
    task automatic t_diag();
        @(posedge clk);
        diagIn <= {5'h10, 16'hA5C3, 16'h5A3C, 12'hFED, 11'h5B7, 9'h16D};
        rdchk(PWM_IN_DUTY_DIAG_OFS, 16'hA5C3);
        rdchk(PWM_OUT_DUTY_DIAG_OFS, 16'h5A3C);
        rdchk(LED_CURRENT_CODE_DIAG_OFS, 16'h0FED);
        rdchk(BOOST_VOLTAGE_CODE_DIAG_OFS, 16'h05B7);
        rdchk(LED_FAULT_STATUS_OFS, 16'h016D);
        host.wr(LED_FAULT_STATUS_OFS, 16'h81FF);
        host.wr(LED_CURRENT_CODE_DIAG_OFS, 16'hFFFF);
        host.wr(BOOST_FAULT_STATUS_OFS, 16'h4000);
        rdchk(LED_FAULT_STATUS_OFS, 16'h016D);
        rdchk(LED_CURRENT_CODE_DIAG_OFS, 16'h0FED);
        rdchk(BOOST_FAULT_STATUS_OFS, REG_RESET);
        rdchk(8'h30, 16'h0000);
        for (int k = 0; k < 20; k++)
        begin
            @(posedge clk);
            diagIn.liveStateCode <= k[4:0];
            rdchk(STATE_MACHINE_DIAG_OFS, {11'h000, k[4:0]});
        end
    endtask
    // An event that arrives while the clock enable is low must be lost.
    task automatic t_freeze();
        fsdr_evt_s e;
        e = '0;
        e.led[1] = 1'b1;
        @(posedge clk);
        clkEn <= 1'b0;
        pulse(e);
        @(posedge clk);
        clkEn <= 1'b1;
        rdchk(LED_FAULT_STATUS_OFS, 16'h016D);
        irq(1'b0);
    endtask

    // Reset for 16 cycles, then run every scenario.
    initial
    begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        t_faults();
        t_enable();
        t_diag();
        t_freeze();
        summarize();
    end
endmodule
